// ---- core/scp_command_port.v ----
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.vh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// RULE_01 - setup: code 14h, attribute byte, rest ignored
// RULE_02 - setup response echoes code, rest meaningless
// RULE_03 - master: mosi,sck out; miso in; ss kept
// RULE_04 - slave: mosi,sck,ss in; miso out
// RULE_05 - disable still sets master-style directions
// RULE_06 - attribute bits 1:0 pick shift rate
// RULE_07 - attribute bits 3:2 pick polarity, sample edge
// RULE_08 - attribute bits 5:4 pick mode
// RULE_09 - host never writes mode 11, bits 7:6
// RULE_10 - transfer: code 15h, count 0-6, data
// RULE_11 - one received byte per sent byte
// RULE_12 - response: code, count, received bytes in order
// RULE_13 - each pulse shifts out and samples one bit
// RULE_14 - master drives no slave select line
// RULE_15 - host frames slave select around transfer
// RULE_16 - host sends dummy bytes to only receive
// RULE_17 - msb first both directions
// RULE_18 - zero count gives no pulses, count zero
module scp_command_port (
	// clock and reset
	input wire mclk,
	input wire reset_n,
	// command bytes from the host, eight per command
	input wire cmd_valid,
	output reg cmd_ready_ff,
	input wire [7:0] cmd_data,
	// response bytes to the host, eight per command
	output reg rsp_valid_ff,
	input wire rsp_ready,
	output reg [7:0] rsp_data_ff,
	// port a direction override (a port a direction command elsewhere)
	input wire dir_load,
	input wire [7:0] dir_value,
	// port a pins
	input wire [7:0] pa_in,
	output reg [7:0] pa_out_ff,
	output reg [7:0] pa_oe_ff,
	// status
	output reg [1:0] spi_mode_ff,
	output reg busy_ff
);
	localparam ST_RECV = 5'b00001;
	localparam ST_DECODE = 5'b00010;
	localparam ST_SHIFT = 5'b00100;
	localparam ST_NEXT = 5'b01000;
	localparam ST_REPLY = 5'b10000;
	// half periods are worked out at 32 bits and cut to the tick counter width
	localparam [31:0] HALF0_W = `SCP_HALF0;
	localparam [31:0] HALF1_W = `SCP_HALF1;
	localparam [31:0] HALF2_W = `SCP_HALF2;
	localparam [31:0] HALF3_W = `SCP_HALF3;
	reg [4:0] state_ff;
	reg [2:0] idx_ff;
	reg [7:0] frame_ff [0:7];
	reg [7:0] attr_ff;
	reg [2:0] cnt_ff;
	reg [2:0] byte_ff;
	reg [3:0] bit_ff;
	reg [7:0] tx_ff;
	reg [7:0] rx_ff;
	reg sclk_ff;
	reg phase_ff;
	reg [11:0] tick_ff;
	reg miso_s1_ff;
	reg miso_s2_ff;
	reg [7:0] rsp_pick;
	reg [11:0] half_cnt;
	wire cpol;
	wire sample_on_rise;
	wire cpha_lead;
	wire tick_done;
	wire [2:0] cnt_req;
	wire [2:0] slot;
	wire out_valid;
	wire out_ready;
	wire [7:0] out_data;
	wire buf_in_ready;
	reg buf_in_valid;
	reg [2:0] out_idx_ff;
	integer i;
	assign cpol = attr_ff[`SCP_ATTR_POL]; // RULE_07
	// sample edge is rising for 01 and 10 encodings
	assign sample_on_rise = attr_ff[`SCP_ATTR_POL] ^ attr_ff[`SCP_ATTR_PHA]; // RULE_07
	// first edge of a pulse is the sample edge when sampling matches idle-to-active direction
	assign cpha_lead = (sample_on_rise == ~cpol);
	assign tick_done = (tick_ff == half_cnt - 12'h1);
	// byte_ff is at most five while shifting, so the frame slot stays inside two..seven
	assign slot = byte_ff + 3'h2;
	// counts above six are clamped; the host keeps to zero..six
	assign cnt_req = (frame_ff[1][2:0] > `SCP_MAX_BYTES || frame_ff[1][7:3] != 5'h0) ?
		`SCP_MAX_BYTES : frame_ff[1][2:0]; // RULE_10
	always @* begin
		case (attr_ff[`SCP_ATTR_RATE_HI:`SCP_ATTR_RATE_LO]) // RULE_06
			2'h0: half_cnt = HALF0_W[11:0];
			2'h1: half_cnt = HALF1_W[11:0];
			2'h2: half_cnt = HALF2_W[11:0];
			default: half_cnt = HALF3_W[11:0];
		endcase
	end
	//////////////////////////////////////////////////////////////////////////////
	// miso synchroniser
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			miso_s1_ff <= 1'b0;
			miso_s2_ff <= 1'b0;
		end else begin
			miso_s1_ff <= pa_in[`SCP_PA_MISO];
			miso_s2_ff <= miso_s1_ff;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	// response byte selection
	always @* begin
		rsp_pick = 8'h00;
		buf_in_valid = (state_ff == ST_REPLY);
		if (out_idx_ff == 3'h0) begin
			rsp_pick = frame_ff[0]; // RULE_02 RULE_12
		end else if (frame_ff[0] == `SCP_CMD_XFER) begin
			rsp_pick = frame_ff[out_idx_ff]; // RULE_11 RULE_12
		end
	end
	scp_skid #(
		.WIDTH(8)
	) u_skid (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(rsp_pick),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);
	// output register acts as a third stage; drained only by the host
	assign out_ready = !rsp_valid_ff || rsp_ready;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
		end else if (out_ready) begin
			rsp_valid_ff <= out_valid;
			rsp_data_ff <= out_data;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	// command sequencer and shifter
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_RECV;
			idx_ff <= 3'h0;
			out_idx_ff <= 3'h0;
			for (i = 0; i < 8; i = i + 1) begin
				frame_ff[i] <= 8'h00;
			end
			attr_ff <= 8'h00;
			cnt_ff <= 3'h0;
			byte_ff <= 3'h0;
			bit_ff <= 4'h0;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			sclk_ff <= 1'b0;
			phase_ff <= 1'b0;
			tick_ff <= 12'h000;
			cmd_ready_ff <= 1'b1;
			busy_ff <= 1'b0;
			spi_mode_ff <= `SCP_MODE_OFF;
			pa_out_ff <= 8'h00;
			pa_oe_ff <= 8'h00;
		end else begin
			if (dir_load) begin
				pa_oe_ff <= dir_value; // RULE_05
			end
			case (state_ff)
				ST_RECV: begin
					if (cmd_valid && cmd_ready_ff) begin
						frame_ff[idx_ff] <= cmd_data; // RULE_01 RULE_10
						idx_ff <= idx_ff + 3'h1;
						if (idx_ff == `SCP_LAST_INDEX) begin
							cmd_ready_ff <= 1'b0;
							busy_ff <= 1'b1;
							state_ff <= ST_DECODE;
						end
					end
				end
				ST_DECODE: begin
					out_idx_ff <= 3'h0;
					if (frame_ff[0] == `SCP_CMD_SETUP) begin
						attr_ff <= frame_ff[1]; // RULE_01 RULE_09
						spi_mode_ff <= frame_ff[1][`SCP_ATTR_MODE_HI:`SCP_ATTR_MODE_LO]; // RULE_08
						sclk_ff <= frame_ff[1][`SCP_ATTR_POL]; // RULE_07
						pa_out_ff[`SCP_PA_SCK] <= frame_ff[1][`SCP_ATTR_POL];
						if (frame_ff[1][`SCP_ATTR_MODE_HI:`SCP_ATTR_MODE_LO] == `SCP_MODE_SLAVE) begin
							pa_oe_ff[`SCP_PA_MOSI] <= 1'b0; // RULE_04
							pa_oe_ff[`SCP_PA_SCK] <= 1'b0;
							pa_oe_ff[`SCP_PA_SS] <= 1'b0;
							pa_oe_ff[`SCP_PA_MISO] <= 1'b1;
						end else begin
							// off and master alike; ss direction untouched
							pa_oe_ff[`SCP_PA_MOSI] <= 1'b1; // RULE_03 RULE_05 RULE_14
							pa_oe_ff[`SCP_PA_SCK] <= 1'b1;
							pa_oe_ff[`SCP_PA_MISO] <= 1'b0;
						end
						state_ff <= ST_REPLY;
					end else if (frame_ff[0] == `SCP_CMD_XFER && spi_mode_ff == `SCP_MODE_MASTER
						&& cnt_req != 3'h0) begin
						cnt_ff <= cnt_req;
						byte_ff <= 3'h0;
						state_ff <= ST_NEXT;
					end else begin
						// zero count or not a master: no pulses, count reported as zero
						if (frame_ff[0] == `SCP_CMD_XFER) begin
							frame_ff[1] <= 8'h00; // RULE_18
						end
						state_ff <= ST_REPLY;
					end
				end
				ST_NEXT: begin
					tx_ff <= frame_ff[slot];
					bit_ff <= 4'h0;
					phase_ff <= 1'b0;
					tick_ff <= 12'h000;
					// leading-sample formats present the msb before the first edge
					pa_out_ff[`SCP_PA_MOSI] <= frame_ff[slot][7]; // RULE_17
					state_ff <= ST_SHIFT;
				end
				ST_SHIFT: begin
					tick_ff <= tick_done ? 12'h000 : tick_ff + 12'h001;
					if (tick_done) begin
						sclk_ff <= ~sclk_ff;
						pa_out_ff[`SCP_PA_SCK] <= ~sclk_ff; // RULE_13
						phase_ff <= ~phase_ff;
						if (phase_ff == 1'b0) begin
							if (cpha_lead) begin
								rx_ff <= {rx_ff[6:0], miso_s2_ff}; // RULE_13 RULE_17
							end else begin
								pa_out_ff[`SCP_PA_MOSI] <= tx_ff[7];
								tx_ff <= {tx_ff[6:0], 1'b0};
							end
						end else begin
							if (cpha_lead) begin
								tx_ff <= {tx_ff[6:0], 1'b0};
								pa_out_ff[`SCP_PA_MOSI] <= tx_ff[6];
							end else begin
								rx_ff <= {rx_ff[6:0], miso_s2_ff}; // RULE_13 RULE_17
							end
							bit_ff <= bit_ff + 4'h1;
							if (bit_ff == `SCP_BITS_PER_BYTE - 4'h1) begin
								// leading-sample formats shifted before completing the pulse
								frame_ff[slot] <= cpha_lead ? rx_ff :
									{rx_ff[6:0], miso_s2_ff}; // RULE_11
								byte_ff <= byte_ff + 3'h1;
								if (byte_ff + 3'h1 == cnt_ff) begin
									frame_ff[1] <= {5'h00, cnt_ff}; // RULE_12
									state_ff <= ST_REPLY;
								end else begin
									state_ff <= ST_NEXT;
								end
							end
						end
					end
				end
				ST_REPLY: begin
					if (buf_in_ready) begin
						out_idx_ff <= out_idx_ff + 3'h1;
						if (out_idx_ff == `SCP_LAST_INDEX) begin
							idx_ff <= 3'h0;
							cmd_ready_ff <= 1'b1;
							busy_ff <= 1'b0;
							state_ff <= ST_RECV;
						end
					end
				end
				default: begin
					state_ff <= ST_RECV;
				end
			endcase
		end
	end
endmodule // scp_command_port
`default_nettype wire

// ---- shared/scp_defines.vh ----
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH
// command codes
`define SCP_CMD_SETUP 8'h14
`define SCP_CMD_XFER 8'h15
// attribute byte fields
`define SCP_ATTR_RATE_LO 0
`define SCP_ATTR_RATE_HI 1
`define SCP_ATTR_POL 3
`define SCP_ATTR_PHA 2
`define SCP_ATTR_MODE_LO 4
`define SCP_ATTR_MODE_HI 5
// mode codes
`define SCP_MODE_OFF 2'h0
`define SCP_MODE_MASTER 2'h1
`define SCP_MODE_SLAVE 2'h2
// port a line numbers
`define SCP_PA_SS 4
`define SCP_PA_MOSI 5
`define SCP_PA_MISO 6
`define SCP_PA_SCK 7
// bit rates in bit/s and the system clock in Hz
`define SCP_CLK_HZ 200000000
`define SCP_RATE0_BPS 2000000
`define SCP_RATE1_BPS 1000000
`define SCP_RATE2_BPS 500000
`define SCP_RATE3_BPS 62500
// half-period counts: a longest time, so round down
`define SCP_HALF0 (`SCP_CLK_HZ / (2 * `SCP_RATE0_BPS))
`define SCP_HALF1 (`SCP_CLK_HZ / (2 * `SCP_RATE1_BPS))
`define SCP_HALF2 (`SCP_CLK_HZ / (2 * `SCP_RATE2_BPS))
`define SCP_HALF3 (`SCP_CLK_HZ / (2 * `SCP_RATE3_BPS))
`define SCP_MAX_BYTES 3'h6
`define SCP_BITS_PER_BYTE 4'h8
`define SCP_FRAME_BYTES 4'h8
`define SCP_LAST_INDEX 3'h7
`endif

// ---- core/scp_skid.v ----
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer; input ready depends only on fill, so a stalled sink loses nothing
module scp_skid #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire mclk,
	input wire reset_n,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_ff [0:1];
	reg rd_ptr_ff;
	reg wr_ptr_ff;
	reg [1:0] count_ff;
	wire push;
	wire pop;
	assign in_ready = (count_ff != 2'h2);
	assign out_valid = (count_ff != 2'h0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always @(posedge mclk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_ptr_ff <= 1'b0;
			wr_ptr_ff <= 1'b0;
			count_ff <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			case ({push, pop})
				2'b10: count_ff <= count_ff + 2'h1;
				2'b01: count_ff <= count_ff - 2'h1;
				default: count_ff <= count_ff;
			endcase
		end
	end
endmodule // scp_skid
`default_nettype wire

// ---- dv/scp_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module scp_checker (
	// clock, reset and host side
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire logic cmd_ready_ff,
	input wire logic [7:0] cmd_data,
	input wire logic rsp_valid_ff,
	input wire logic rsp_ready,
	input wire logic [7:0] rsp_data_ff,
	// pins and status
	input wire logic dir_load,
	input wire logic [7:0] pa_out_ff,
	input wire logic [7:0] pa_oe_ff,
	input wire logic [1:0] spi_mode_ff,
	input wire logic busy_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic [2:0] n_ff, r_ff;
	logic [7:0] op_ff, b1_ff;
	wire tk = cmd_valid && cmd_ready_ff;
	wire dn = tk && n_ff == 3'h7;
	wire su = dn && op_ff == 8'h14;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			n_ff <= 3'h0;
			r_ff <= 3'h0;
			op_ff <= 8'h00;
			b1_ff <= 8'h00;
		end else begin
			n_ff <= n_ff + {2'h0, tk};
			r_ff <= r_ff + {2'h0, rsp_valid_ff && rsp_ready};
			if (tk && n_ff == 3'h0) op_ff <= cmd_data;
			if (tk && n_ff == 3'h1) b1_ff <= cmd_data;
		end
	end
	a_master_dirs: assert property (su && b1_ff[5:4] != 2'h2 |-> ##[1:4] pa_oe_ff[7:5] == 3'h5)
		else $error("master directions wrong");
	a_slave_dirs: assert property (su && b1_ff[5:4] == 2'h2 |-> ##[1:4] pa_oe_ff[7:4] == 4'h4)
		else $error("slave directions wrong");
	// select line direction belongs to the host once in master mode
	a_ss_kept: assert property (!busy_ff && spi_mode_ff == 2'h1 && !$past(dir_load) |-> $stable(pa_oe_ff[4]))
		else $error("select direction moved");
	a_sck_quiet: assert property (!busy_ff ##1 !busy_ff |-> $stable(pa_out_ff[7]))
		else $error("clock moved while idle");
	a_zero_quiet: assert property (dn && op_ff == 8'h15 && b1_ff == 8'h00 |=> $stable(pa_out_ff[7])[*8])
		else $error("pulses on zero count");
	a_code_echo: assert property (rsp_valid_ff && r_ff == 3'h0 |-> rsp_data_ff == op_ff)
		else $error("code not echoed");
	a_count_echo: assert property (rsp_valid_ff && r_ff == 3'h1 && op_ff == 8'h15 && spi_mode_ff == 2'h1
		&& b1_ff < 8'h07 |-> rsp_data_ff == b1_ff)
		else $error("count not echoed");
	a_rsp_hold: assert property (rsp_valid_ff && !rsp_ready |=> rsp_valid_ff && $stable(rsp_data_ff))
		else $error("response byte lost");
	c_slave: cover property (su && b1_ff[5:4] == 2'h2);
	c_full: cover property (dn && op_ff == 8'h15 && b1_ff == 8'h06);
	c_stall: cover property (rsp_valid_ff && !rsp_ready);
endmodule // scp_checker
bind scp_command_port scp_checker u_chk (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
	.cmd_ready_ff(cmd_ready_ff), .cmd_data(cmd_data), .rsp_valid_ff(rsp_valid_ff),
	.rsp_ready(rsp_ready), .rsp_data_ff(rsp_data_ff), .dir_load(dir_load), .pa_out_ff(pa_out_ff),
	.pa_oe_ff(pa_oe_ff), .spi_mode_ff(spi_mode_ff), .busy_ff(busy_ff));
`default_nettype wire

// ---- dv/scp_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scp_slave_model (
	// serial lines
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	output logic miso,
	// clock mode and first reply byte
	input wire logic [1:0] cmode,
	input wire logic [7:0] tx_base
);
	logic [7:0] got [8];
	logic [7:0] cur;
	int samp = 0;
	int idx = 0;
	// modes 01 and 10 sample on the rising edge
	wire rise_s = cmode[1] ^ cmode[0];
	always @(negedge ss_n) begin
		samp = 0;
		idx = 0;
	end
	always @(sck) begin
		if (!ss_n && sck == rise_s) begin
			got[samp / 8] = {got[samp / 8][6:0], mosi};
			samp = samp + 1;
		end else if (!ss_n) begin
			idx = samp;
		end
	end
	// deselected, the line shows the inverse so a stale bit never reads as good
	always @* begin
		cur = tx_base + 8'(idx / 8) * 8'h3b;
		miso = ss_n ? ~cur[7 - idx % 8] : cur[7 - idx % 8];
	end
endmodule // scp_slave_model
`default_nettype wire

// ---- dv/scp_command_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.vh"
module scp_command_port_test;
	logic mclk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, rsp_ready = 1'b0, dir_load = 1'b0;
	logic ss_n = 1'b1;
	logic [7:0] cmd_data = 8'h00, dir_value = 8'h00, tx_base = 8'h00;
	logic [1:0] cmode = 2'h0;
	wire cmd_ready_ff, rsp_valid_ff, busy_ff, miso;
	wire [7:0] rsp_data_ff, pa_out_ff, pa_oe_ff;
	wire [1:0] spi_mode_ff;
	logic [7:0] rsp [8];
	logic [7:0] sent [8];
	int half [4] = '{`SCP_HALF0, `SCP_HALF1, `SCP_HALF2, `SCP_HALF3};
	int n_mismatch = 0, comparisons = 0, pulses = 0;
	realtime t0 = 0.0, t1 = 0.0;
	scp_command_port dut (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_ready_ff(cmd_ready_ff), .cmd_data(cmd_data), .rsp_valid_ff(rsp_valid_ff),
		.rsp_ready(rsp_ready), .rsp_data_ff(rsp_data_ff), .dir_load(dir_load),
		.dir_value(dir_value), .pa_in({pa_out_ff[7], miso, pa_out_ff[5:0]}),
		.pa_out_ff(pa_out_ff), .pa_oe_ff(pa_oe_ff), .spi_mode_ff(spi_mode_ff), .busy_ff(busy_ff));
	scp_slave_model u_slv (.sck(pa_out_ff[7]), .mosi(pa_out_ff[5]), .ss_n(ss_n), .miso(miso),
		.cmode(cmode), .tx_base(tx_base));
	always #2.5 mclk = ~mclk;
	always @(posedge pa_out_ff[7]) pulses++;
	always @(pa_out_ff[7]) begin
		if (t0 == 0.0) t0 = $realtime;
		t1 = $realtime;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_rx(int k);
		return tx_base + 8'(k) * 8'h3b;
	endfunction
	// fillers are random; the host stalls at random so the buffer must hold
	task automatic run_cmd(input logic [7:0] b0, input logic [7:0] b1);
		int w;
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk);
			cmd_valid = 1'b1;
			cmd_data = (i == 0) ? b0 : (i == 1) ? b1 : 8'($urandom);
			sent[i] = cmd_data;
			w = 0;
			// ready moves only on rising edges, so its falling-edge value is what gets sampled
			while (cmd_ready_ff !== 1'b1 && w++ < 50) @(negedge mclk);
			if (w > 50) begin
				n_mismatch++;
				$display("[FAIL] %0t command byte not taken", $time);
			end
			@(posedge mclk);
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
		for (int i = 0; i < 8; i++) begin
			w = 0;
			do begin
				@(negedge mclk);
				rsp_ready = ($urandom % 3) != 0;
			end while (!(rsp_valid_ff === 1'b1 && rsp_ready) && w++ < 40000);
			if (w > 40000) begin
				n_mismatch++;
				$display("[FAIL] %0t response byte missing", $time);
			end
			rsp[i] = rsp_data_ff;
			@(posedge mclk);
		end
		@(negedge mclk);
		rsp_ready = 1'b0;
		check(rsp[0], b0);
	endtask
	task automatic xfer(input logic [3:0] cr, input int n);
		cmode = cr[3:2];
		tx_base = 8'($urandom);
		run_cmd(`SCP_CMD_SETUP, {4'h1, cr});
		check(pa_out_ff[7], cr[3]);
		ss_n = 1'b0;
		pulses = 0;
		t0 = 0.0;
		run_cmd(`SCP_CMD_XFER, 8'(n));
		ss_n = 1'b1;
		check(rsp[1], n);
		check(pulses, 8 * n);
		// one reload cycle sits between bytes, on top of the half periods
		if (n > 0) check(int'((t1 - t0) / 5.0), (16 * n - 1) * half[cr[1:0]] + n - 1);
		for (int k = 0; k < n; k++) begin
			check(rsp[2 + k], exp_rx(k));
			check(u_slv.got[k], sent[2 + k]);
		end
		$display("transfer mode %h count %0d done", cr, n);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		void'($urandom(67));
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		reset_n = 1'b1;
		for (int m = 0; m < 3; m++) begin
			@(negedge mclk);
			dir_load = 1'b1;
			dir_value = 8'($urandom);
			@(negedge mclk);
			dir_load = 1'b0;
			run_cmd(`SCP_CMD_SETUP, {2'h0, 2'(m), 4'($urandom)});
			check(spi_mode_ff, m);
			check(pa_oe_ff, m == 2 ? {4'h4, dir_value[3:0]} : {3'h5, dir_value[4:0]});
			$display("setup mode %0d done", m);
		end
		// still in slave mode here: a transfer must not clock and reports nothing exchanged
		pulses = 0;
		run_cmd(`SCP_CMD_XFER, 8'h03);
		check(rsp[1], 0);
		check(pulses, 0);
		$display("transfer outside master mode done");
		xfer(4'h0, 6);
		xfer(4'h5, 1 + $urandom % 5);
		xfer(4'ha, 1 + $urandom % 3);
		xfer(4'hf, 1);
		xfer(4'h0, 0);
		close_out();
	end
	initial begin
		#450us;
		n_mismatch++;
		close_out();
	end
endmodule // scp_command_port_test
`default_nettype wire
